//--- hdl/ptd_cfg.svh
`ifndef PTD_CFG_SVH
`define PTD_CFG_SVH
// ----------------------------------------
// Character codes, seven-bit form
// ----------------------------------------
`define PTD_CHAR_START 7'h42
`define PTD_CHAR_STOP 7'h46
`define PTD_CHAR_HIGH 7'h50
`define PTD_CHAR_LOW 7'h4E
// ----------------------------------------
// Memory shape
// ----------------------------------------
`define PTD_WORD_BITS 8
`define PTD_ADDR_BITS 16
`define PTD_CNT_BITS 4
`define PTD_WIDE_CHARS 4'h8
`define PTD_NARROW_CHARS 4'h4
`define PTD_DEPTH_RESET 16'h0100
`endif

//--- hdl/ptd_char_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage capture of a character strobe and its byte from the reader pins
module ptd_char_sync
  import ptd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_strobe,
  input wire logic [7:0] pin_char,
  output logic char_valid,
  output logic [7:0] char_code
);
  logic [1:0] stb_sync;
  logic [7:0] chr_meta;
  logic [7:0] chr_sync;
  logic stb_prev;
  logic [1:0] next_stb_sync;
  logic [7:0] next_chr_sync;
  logic next_stb_prev;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb begin
    next_stb_sync = {stb_sync[0], pin_strobe};
    next_chr_sync = chr_meta;
    next_stb_prev = stb_sync[1];
  end

  // Synchroniser flops; first stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stb_sync <= 2'h0;
      chr_meta <= 8'h00;
      chr_sync <= 8'h00;
      stb_prev <= 1'b0;
    end else begin
      stb_sync <= next_stb_sync;
      chr_meta <= pin_char;
      chr_sync <= next_chr_sync;
      stb_prev <= next_stb_prev;
    end
  end

  // Rising edge of the settled strobe marks one character
  assign char_valid = stb_sync[1] & ~stb_prev;
  assign char_code = chr_sync;
endmodule // ptd_char_sync
`default_nettype wire

//--- hdl/ptd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptd_cfg.svh"
// Operation
// - The first field goes to address zero and each later field to the next address.
// - A count of fields that differs from the configured depth at tape end is a fault.
// - A field opens with B and closes with F and is recognised only between that pair.
// - A field holds exactly eight or four data characters by width, else a field error.
// - Any character other than P or N inside a field, rubouts included, is an error.
// - P gives a one and N gives a zero in the word.
// - The first data character lands in bit 7 (wide) or bit 3 (narrow), the last in the least.
// - Everything outside a delimited field is ignored.
// - Seven-bit and eight-bit character codes are both accepted.
module ptd_decoder
  import ptd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_strobe,
  input wire logic [7:0] pin_char,
  input wire logic wide_mode,
  input wire logic [`PTD_ADDR_BITS-1:0] depth,
  input wire logic tape_end,
  output ptd_word_type word_out,
  output logic word_valid,
  output ptd_fault_type fault,
  output logic error,
  output logic tape_done
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // Parser states
  typedef enum logic [1:0] {
    PTD_IDLE,
    PTD_FIELD,
    PTD_SKIP
  } ptd_state_type;

  // Character path
  logic char_valid;
  logic [7:0] char_code;
  ptd_class_type cls;
  ptd_state_type state, next_state;
  logic [`PTD_WORD_BITS-1:0] shift, next_shift;
  logic [`PTD_CNT_BITS-1:0] count, next_count;
  logic [`PTD_ADDR_BITS-1:0] addr, next_addr;
  ptd_word_type next_word_out;
  logic next_word_valid;
  ptd_fault_type next_fault;
  // Tape end path
  logic [1:0] end_sync;
  logic [1:0] next_end_sync;
  logic end_prev, next_end_prev;
  logic next_tape_done;
  logic [`PTD_CNT_BITS-1:0] need;
  logic end_edge;

  // ----------------------------------------
  // Character capture
  // ----------------------------------------
  // Strobe and byte pass two flops each
  ptd_char_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_strobe(pin_strobe),
    .pin_char(pin_char),
    .char_valid(char_valid),
    .char_code(char_code)
  );

  // ----------------------------------------
  // Character decode
  // ----------------------------------------
  // Classify on the low seven bits only
  function automatic ptd_class_type classify(input logic [7:0] c);
    logic [6:0] low;
    low = c[6:0];
    case (low)
      `PTD_CHAR_START: classify = PTD_CLS_START;
      `PTD_CHAR_STOP: classify = PTD_CLS_STOP;
      `PTD_CHAR_HIGH: classify = PTD_CLS_HIGH;
      `PTD_CHAR_LOW: classify = PTD_CLS_LOW;
      default: classify = PTD_CLS_OTHER;
    endcase
  endfunction

  // Class of the character taken this cycle
  assign cls = classify(char_code);
  // Data characters per field for the selected width
  assign need = wide_mode ? `PTD_WIDE_CHARS : `PTD_NARROW_CHARS;
  // Rising edge of the settled tape end pin
  assign end_edge = end_sync[1] & ~end_prev;

  // ----------------------------------------
  // Field parser
  // ----------------------------------------
  always_comb begin
    // Hold everything but word_valid, which clears, and end_prev, which follows end_sync[1], unless a character or the tape end moves it
    next_state = state;
    next_shift = shift;
    next_count = count;
    next_addr = addr;
    next_word_out = word_out;
    next_word_valid = 1'b0;
    next_fault = fault;
    next_end_prev = end_sync[1];
    next_tape_done = tape_done;
    if (char_valid && !tape_done) begin
      case (state)
        PTD_IDLE: begin
          // Filler, comments and rubbed-out fields pass here
          if (cls == PTD_CLS_START) begin
            next_state = PTD_FIELD;
            next_shift = '0;
            next_count = '0;
          end
        end
        PTD_FIELD: begin
          // Data character; one past the width is a fault
          if (cls == PTD_CLS_HIGH || cls == PTD_CLS_LOW) begin
            if (count == need) begin
              next_fault.field_error = 1'b1;
              next_state = PTD_SKIP;
            end else begin
              // Shift in from the LSB so the first char ends as bit 7 when wide, bit 3 when narrow
              next_shift = {shift[`PTD_WORD_BITS-2:0], cls == PTD_CLS_HIGH};
              next_count = count + `PTD_CNT_BITS'(1);
            end
          end else if (cls == PTD_CLS_STOP) begin
            // Stop closes the field; the address advances either way
            next_state = PTD_IDLE;
            if (count != need) begin
              next_fault.field_error = 1'b1;
            end else begin
              next_word_out.addr = addr;
              next_word_out.data = shift;
              next_word_valid = 1'b1;
            end
            next_addr = addr + `PTD_ADDR_BITS'(1);
          end else begin
            // Any other character spoils the field
            next_fault.field_error = 1'b1;
            next_state = PTD_SKIP;
          end
        end
        PTD_SKIP: begin
          // Bad field, wait for its stop and still count it
          if (cls == PTD_CLS_STOP) begin
            next_state = PTD_IDLE;
            next_addr = addr + `PTD_ADDR_BITS'(1);
          end
        end
        default: next_state = PTD_IDLE;
      endcase
    end
    // Count check at tape end
    // An open field at that point also counts as a short tape
    if (end_edge && !tape_done) begin
      next_tape_done = 1'b1;
      if (addr != depth || state != PTD_IDLE) begin
        next_fault.count_error = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Parser registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= PTD_IDLE;
      shift <= '0;
      count <= '0;
      addr <= '0;
      word_out <= '0;
      word_valid <= 1'b0;
      fault <= '0;
      end_prev <= 1'b0;
      tape_done <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      count <= next_count;
      addr <= next_addr;
      word_out <= next_word_out;
      word_valid <= next_word_valid;
      fault <= next_fault;
      end_prev <= next_end_prev;
      tape_done <= next_tape_done;
    end
  end

  // ----------------------------------------
  // Tape end synchroniser
  // ----------------------------------------
  // Two flops; only the second stage is read by the parser
  always_comb begin
    next_end_sync = {end_sync[0], tape_end};
  end

  // Synchroniser flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      end_sync <= 2'h0;
    end else begin
      end_sync <= next_end_sync;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Sticky summary of both fault kinds
  assign error = fault.field_error | fault.count_error;
endmodule // ptd_decoder
`default_nettype wire

//--- hdl/ptd_pkg.sv
`default_nettype none
package ptd_pkg;
`include "ptd_cfg.svh"
  // Character classes
  typedef enum logic [2:0] {
    PTD_CLS_START,
    PTD_CLS_STOP,
    PTD_CLS_HIGH,
    PTD_CLS_LOW,
    PTD_CLS_OTHER
  } ptd_class_type;

  // Decoded word with its address
  typedef struct packed {
    logic [`PTD_ADDR_BITS-1:0] addr;
    logic [`PTD_WORD_BITS-1:0] data;
  } ptd_word_type;

  // Fault flags
  typedef struct packed {
    logic field_error;
    logic count_error;
  } ptd_fault_type;
endpackage
`default_nettype wire

//--- sim/ptd_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Decoder output checks
// ----
module ptd_chk
  import ptd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_strobe,
  input wire logic [7:0] pin_char,
  input wire logic wide_mode,
  input wire logic [15:0] depth,
  input wire logic tape_end,
  input wire ptd_word_type word_out,
  input wire logic word_valid,
  input wire ptd_fault_type fault,
  input wire logic error,
  input wire logic tape_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Flags, strobes and their causes
  a_error_or: assert property (error == (fault.field_error | fault.count_error))
    else $error("error flag mismatch");
  a_field_sticky: assert property (fault.field_error |=> fault.field_error)
    else $error("field fault dropped");
  a_count_sticky: assert property (fault.count_error |=> fault.count_error)
    else $error("count fault dropped");
  a_done_sticky: assert property (tape_done |=> tape_done)
    else $error("tape end dropped");
  a_valid_pulse: assert property (word_valid |=> !word_valid)
    else $error("strobe too long");
  a_valid_cause: assert property (word_valid |-> $past(pin_char[6:0], 3) == 7'h46)
    else $error("word without stop");
  a_narrow_top: assert property (word_valid && !wide_mode |-> word_out.data[7:4] == 4'h0)
    else $error("narrow word top bits");
  a_done_cause: assert property ($rose(tape_done) |-> $past(tape_end, 3))
    else $error("tape end without pin");
endmodule // ptd_chk
bind ptd_decoder ptd_chk u_chk (.core_clk, .rst, .pin_strobe, .pin_char, .wide_mode, .depth,
  .tape_end, .word_out, .word_valid, .fault, .error, .tape_done);
`default_nettype wire

//--- sim/ptd_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Decoder bench
// ----
module ptd_decoder_bench
  import ptd_pkg::*;
;
  logic core_clk, rst, pin_strobe, wide_mode, tape_end, word_valid, error, tape_done;
  logic [7:0] pin_char;
  logic [15:0] depth;
  ptd_word_type word_out;
  ptd_fault_type fault;
  ptd_word_type wq[$];
  int error_cnt = 0;
  int total_checks = 0;
  ptd_decoder u_dut (.core_clk, .rst, .pin_strobe, .pin_char, .wide_mode, .depth, .tape_end,
    .word_out, .word_valid, .fault, .error, .tape_done);
  ptd_tape_src u_src (.core_clk, .pin_strobe, .pin_char);
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Word capture
  always @(negedge core_clk) if (word_valid === 1'b1) wq.push_back(word_out);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reset, configure, leader
  task automatic start(input logic w, input logic [15:0] d);
    @(posedge core_clk) #1;
    rst = 1'b1;
    tape_end = 1'b0;
    wide_mode = w;
    depth = d;
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    wq.delete();
    u_src.filler();
  endtask
  // Trailer then tape end
  task automatic end_tape();
    u_src.filler();
    #1 tape_end = 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
  // Wide words, mixed codes, rubbed-out field, exact count
  task automatic t_wide();
    start(1'b1, 16'h0003);
    u_src.put_str("\015\012BPNPNNNPPF", 1'b0);
    u_src.put_str("w1 BNNNNNNNPF", 1'b1);
    repeat (10) u_src.put(8'h7F);
    u_src.put_str("\015\012BPPPPPPPNF", 1'b0);
    end_tape();
    chk(24'(wq.size()), 24'h3);
    chk(wq[0], {16'h0000, 8'hA3});
    chk(wq[1], {16'h0001, 8'h01});
    chk(wq[2], {16'h0002, 8'hFE});
    chk(24'({tape_done, error, fault}), 24'h8);
  endtask
  // Narrow words, bad fields, short count, ignored after end
  task automatic t_narrow();
    start(1'b0, 16'h0006);
    u_src.put_str("BPNNPF BPNPF BPN\177NF BPNPNNF BNNNPF", 1'b0);
    end_tape();
    u_src.put_str("BPPPPF", 1'b0);
    repeat (6) @(posedge core_clk);
    chk(24'(wq.size()), 24'h2);
    chk(wq[0], {16'h0000, 8'h09});
    chk(wq[1], {16'h0004, 8'h01});
    chk(24'({tape_done, error, fault}), 24'hF);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    tape_end = 1'b0;
    wide_mode = 1'b1;
    depth = 16'h0000;
    t_wide();
    t_narrow();
    final_report();
  end
  // Watchdog
  initial begin
    #160000;
    error_cnt++;
    final_report();
  end
endmodule // ptd_decoder_bench
`default_nettype wire

//--- sim/ptd_tape_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Tape reader model
// ----
module ptd_tape_src (
  input wire logic core_clk,
  output logic pin_strobe,
  output logic [7:0] pin_char
);
  // Idle lines
  initial begin
    pin_strobe = 1'b0;
    pin_char = 8'h00;
  end
  // One character per strobe, data scrambled once hold time is over
  task automatic put(input logic [7:0] c);
    @(posedge core_clk) #1;
    pin_strobe = 1'b1;
    pin_char = c;
    repeat (3) @(posedge core_clk);
    #1 pin_char = ~c;
    @(posedge core_clk) #1;
    pin_strobe = 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // Text, seven-bit or with the eighth bit set
  task automatic put_str(input string s, input logic hi);
    for (int i = 0; i < s.len(); i++) put(8'(s[i]) | {hi, 7'h00});
  endtask
  // Rubout leader or trailer
  task automatic filler();
    repeat (25) put(8'h7F);
  endtask
endmodule // ptd_tape_src
`default_nettype wire
